// ---- rtl/dspb_pkg.sv ----
// constants and carrier types shared by the stream pre-fetch buffer files
package dspb_pkg;

    localparam int ADDR_W       = 32;
    localparam int NUM_ENTRIES  = 8;
    localparam int SLOT_W       = 3;
    localparam int LINE_BYTES   = 128;
    localparam int HALF_BYTES   = 64;
    localparam int HALF_OFS_W   = 6;
    localparam int HALF_IDX_W   = ADDR_W - HALF_OFS_W;
    localparam int HALF_BITS    = HALF_BYTES * 8;
    localparam int LINE_BITS    = LINE_BYTES * 8;
    localparam int GEN_W        = 3;
    localparam int ID_W         = 4;
    localparam int CAND_DEPTH   = 4;

    // one attribute register per 16 MB region, indexed by the top address byte
    localparam int ATTR_NUM     = 256;
    localparam int ATTR_IDX_W   = 8;
    localparam int ATTR_IDX_LSB = 24;
    localparam logic [ATTR_IDX_W-1:0] ATTR_PFX_RST_LO = 8'h0C;
    localparam logic [ATTR_IDX_W-1:0] ATTR_PFX_RST_HI = 8'h0F;

    // 0x0C000000 .. 0x0FFFFFFF is never held by the level-two cache
    localparam int                    BYPASS_LSB = 26;
    localparam logic [5:0]            BYPASS_TAG = 6'h03;
    localparam logic [HALF_IDX_W-1:0] HALF_STEP  = 26'h000_0001;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic                  pf_hint;
        logic                  from_l2;
        logic [ID_W-1:0]       id;
        logic [ADDR_W-1:0]     addr;
    } dspb_req_t;

    typedef struct packed {
        logic                  valid;
        logic [ID_W-1:0]       id;
        logic [LINE_BITS-1:0]  data;
    } dspb_rsp_t;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [ID_W-1:0]       id;
        logic [ADDR_W-1:0]     addr;
    } dspb_fwd_t;

    typedef struct packed {
        logic                  valid;
        logic [ADDR_W-1:0]     addr;
        logic [SLOT_W-1:0]     slot;
        logic                  half;
        logic [GEN_W-1:0]      gen;
    } dspb_pf_t;

    typedef struct packed {
        logic                  valid;
        logic                  ok;
        logic [SLOT_W-1:0]     slot;
        logic                  half;
        logic [GEN_W-1:0]      gen;
        logic [HALF_BITS-1:0]  data;
    } dspb_ret_t;

    typedef struct packed {
        logic                  valid;
        logic                  supervisor;
        logic [ATTR_IDX_W-1:0] index;
        logic                  cacheable;
        logic                  pf_en;
    } dspb_attr_wr_t;

endpackage

// ---- rtl/dspb_attr.sv ----
// memory attribute registers: cacheable and pre-fetch enable bit per region
`timescale 1ns/1ps
module dspb_attr (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire dspb_pkg::dspb_attr_wr_t           wr,
    input  wire logic [dspb_pkg::ATTR_IDX_W-1:0]   idx,
    output logic                                   cacheable,
    output logic                                   pf_en
);
    import dspb_pkg::*;

    logic [ATTR_NUM-1:0] pc_q;
    logic [ATTR_NUM-1:0] pfx_q;

    wire wr_ok = wr.valid & wr.supervisor;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < ATTR_NUM; i++) begin
                pc_q[i]  <= (i >= ATTR_PFX_RST_LO) && (i <= ATTR_PFX_RST_HI);
                pfx_q[i] <= (i >= ATTR_PFX_RST_LO) && (i <= ATTR_PFX_RST_HI);
            end
        end else if (wr_ok) begin
            pc_q[wr.index]  <= wr.cacheable;
            pfx_q[wr.index] <= wr.pf_en;
        end
    end

    assign cacheable = pc_q[idx];
    assign pf_en     = pfx_q[idx];

endmodule

// ---- rtl/dspb_cand.sv ----
// candidate buffer: remembers the next half after recent misses
`timescale 1ns/1ps
module dspb_cand #(
    parameter int DEPTH = dspb_pkg::CAND_DEPTH
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              ins_valid,
    input  wire logic [dspb_pkg::HALF_IDX_W-1:0]   ins_half,
    input  wire logic [dspb_pkg::HALF_IDX_W-1:0]   look_half,
    input  wire logic                              take,
    output logic                                   hit
);
    import dspb_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [DEPTH-1:0]      valid_q;
    logic [HALF_IDX_W-1:0] tag_q [DEPTH];
    logic [PW-1:0]         wr_ptr_q;
    logic [DEPTH-1:0]      match;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            match[i] = valid_q[i] && (tag_q[i] == look_half);
        end
    end

    assign hit = |match;

    // depth must be a power of two so the pointer wraps by itself
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid_q  <= '0;
            wr_ptr_q <= '0;
        end else if (ins_valid) begin
            valid_q[wr_ptr_q] <= 1'h1;
            wr_ptr_q          <= wr_ptr_q + 1'h1;
        end else if (take) begin
            valid_q <= valid_q & ~match;
        end
    end

    always_ff @(posedge clk) begin
        if (ins_valid) begin
            tag_q[wr_ptr_q] <= ins_half;
        end
    end

endmodule

// ---- rtl/dspb_top.sv ----
// stream pre-fetch buffer inside the external memory controller
`timescale 1ns/1ps
// Summary of operation
// - eight stream entries, each two 64-byte halves
// - allocation pointer names oldest entry to reuse
// - pre-fetchable half-line read hitting empty entry's early half re-fetches late half
// - pre-fetchable late-half buffer hit or candidate hit allocates stream
// - first pre-fetch early half, second next cycle
// - reallocation makes outstanding old pre-fetch stale
// - only newest pre-fetch per half is valid
// - pre-fetch enable bit, regions 12-15 reset set
// - attribute writes accepted only from supervisor
// - cleared enable stops pre-fetch, caching still allowed
// - level-two off, zero or frozen: half-line mode
// - remapped memory outside bypass region stays pre-fetchable
// - data present hits; pending read hits wait
// - address hit without data forwards to memory
// - write hitting stream invalidates that half
// - colliding pre-fetches in pipeline drop the earlier
module dspb_top (
    input  wire logic                    CORE_CLK,
    input  wire logic                    NRST,
    input  wire dspb_pkg::dspb_req_t     REQ,
    output logic                         REQ_READY,
    input  wire dspb_pkg::dspb_attr_wr_t ATTR_WR,
    input  wire logic                    L2_DISABLED,
    input  wire logic                    L2_SIZE_ZERO,
    input  wire logic                    L2_FROZEN,
    output dspb_pkg::dspb_rsp_t          RSP,
    output dspb_pkg::dspb_fwd_t          FWD,
    output dspb_pkg::dspb_pf_t           PF_OUT,
    input  wire logic                    PF_READY,
    input  wire dspb_pkg::dspb_ret_t     PF_RET,
    output logic [dspb_pkg::NUM_ENTRIES-1:0] STREAM_VALID,
    output logic [dspb_pkg::SLOT_W-1:0]  ALLOC_PTR
);
    import dspb_pkg::*;

    // entry state
    logic [NUM_ENTRIES-1:0]                 valid_q;
    logic [HALF_IDX_W-1:0]                  base_q [NUM_ENTRIES];
    logic [NUM_ENTRIES-1:0][1:0]            have_q;
    logic [NUM_ENTRIES-1:0][1:0]            pend_q;
    logic [NUM_ENTRIES-1:0][1:0][GEN_W-1:0] gen_q;
    logic [HALF_BITS-1:0]                   data_q [NUM_ENTRIES][2];
    logic [SLOT_W-1:0]                      ptr_q;

    // issue pipeline and outputs
    dspb_pf_t                               new_pf;
    dspb_pf_t                               pf2_d;
    dspb_pf_t                               pf2_q;
    dspb_pf_t                               stg_q;
    dspb_pf_t                               pfo_q;
    dspb_pf_t                               incoming;
    dspb_rsp_t                              rsp_d;
    dspb_rsp_t                              rsp_q;
    dspb_fwd_t                              fwd_d;
    dspb_fwd_t                              fwd_q;
    logic                                   rdy_q;

    // one outstanding waiting read
    logic                                   wait_v_q;
    logic [ID_W-1:0]                        wait_id_q;
    logic [ADDR_W-1:0]                      wait_addr_q;
    logic [SLOT_W-1:0]                      wait_slot_q;
    logic [1:0]                             wait_need_q;

    // per half controls
    logic [NUM_ENTRIES-1:0][1:0]            bump;
    logic [NUM_ENTRIES-1:0][1:0]            set_p;
    logic [NUM_ENTRIES-1:0][1:0]            ret_hit;

    // lookup results
    logic                                   hit;
    logic [SLOT_W-1:0]                      hit_slot;
    logic                                   hit_half;
    logic                                   attr_pc;
    logic                                   attr_pfx;
    logic                                   cand_hit;

    function automatic logic [1:0] half_match(input logic [HALF_IDX_W-1:0] base,
                                              input logic [HALF_IDX_W-1:0] h);
        half_match = {(base + HALF_STEP) == h, base == h};
    endfunction

    function automatic dspb_pf_t mk_pf(input logic [HALF_IDX_W-1:0] h,
                                       input logic [SLOT_W-1:0]     s,
                                       input logic                  hf,
                                       input logic [GEN_W-1:0]      g);
        mk_pf.valid = 1'h1;
        mk_pf.addr  = {h, {HALF_OFS_W{1'h0}}};
        mk_pf.slot  = s;
        mk_pf.half  = hf;
        mk_pf.gen   = g;
    endfunction

    function automatic logic [LINE_BITS-1:0] pick(input logic [SLOT_W-1:0] s,
                                                  input logic [1:0]        nd);
        pick = (nd == 2'h3) ? {data_q[s][1], data_q[s][0]} : {{HALF_BITS{1'h0}}, data_q[s][nd[1]]};
    endfunction

    wire [HALF_IDX_W-1:0] req_half = REQ.addr[ADDR_W-1:HALF_OFS_W];
    wire [HALF_IDX_W-1:0] pf1_half = req_half + HALF_STEP;
    wire [HALF_IDX_W-1:0] pf2_half = pf1_half + HALF_STEP;

    always_comb begin
        logic [1:0] m;
        m        = '0;
        hit      = 1'h0;
        hit_slot = '0;
        hit_half = 1'h0;
        for (int i = 0; i < NUM_ENTRIES; i++) begin
            m = half_match(base_q[i], req_half);
            if (valid_q[i] && (m != 2'h0) && !hit) begin
                hit      = 1'h1;
                hit_slot = SLOT_W'(i);
                hit_half = m[1];
            end
        end
    end

    dspb_attr u_attr (
        .clk       (CORE_CLK),
        .rst_n     (NRST),
        .wr        (ATTR_WR),
        .idx       (REQ.addr[ADDR_W-1:ATTR_IDX_LSB]),
        .cacheable (attr_pc),
        .pf_en     (attr_pfx)
    );

    // decode of the accepted request
    wire       acc        = REQ.valid & rdy_q;
    wire       rd         = acc & ~REQ.write;
    wire       bypass     = REQ.addr[ADDR_W-1:BYPASS_LSB] == BYPASS_TAG;
    // remapped memory above the bypass region keeps whole-line behaviour
    wire       l1_mode    = ~REQ.from_l2 | L2_DISABLED | L2_SIZE_ZERO | L2_FROZEN | bypass;
    wire       pf_ok      = REQ.pf_hint & attr_pc & attr_pfx;
    wire       oth        = ~hit_half;
    wire [1:0] need       = l1_mode ? (hit_half ? 2'h2 : 2'h1) : 2'h3;
    wire [1:0] e_have     = have_q[hit_slot];
    wire [1:0] e_pend     = pend_q[hit_slot];
    wire       data_hit   = rd & hit & ((e_have & need) == need);
    wire       wait_hit   = rd & hit & ~data_hit & ((e_pend & need) != 2'h0);
    wire       alloc_go   = rd & pf_ok & (cand_hit | (hit & hit_half));
    wire       refetch_go = rd & pf_ok & l1_mode & hit & ~alloc_go & (e_have == 2'h0) & ~e_pend[oth];
    wire       cand_ins   = rd & pf_ok & ~hit & ~cand_hit;
    wire       wr_hit     = acc & REQ.write & hit;

    dspb_cand u_cand (
        .clk       (CORE_CLK),
        .rst_n     (NRST),
        .ins_valid (cand_ins),
        .ins_half  (pf1_half),
        .look_half (req_half),
        .take      (alloc_go),
        .hit       (cand_hit)
    );

    // waiter resolves once none of its halves is pending any more
    wire       wait_done  = wait_v_q & ((pend_q[wait_slot_q] & wait_need_q) == 2'h0);
    wire       wait_ok    = (have_q[wait_slot_q] & wait_need_q) == wait_need_q;
    wire       rdy_d      = ~(wait_hit | (wait_v_q & ~wait_done));
    wire       out_fire   = pfo_q.valid & PF_READY;
    wire       out_free   = ~pfo_q.valid | PF_READY;

    // new pre-fetches of this cycle
    assign new_pf = alloc_go   ? mk_pf(pf1_half, ptr_q, 1'h0, gen_q[ptr_q][0] + 1'h1) :
                    refetch_go ? mk_pf(base_q[hit_slot] + HALF_IDX_W'(oth), hit_slot, oth,
                                       gen_q[hit_slot][oth] + 1'h1) : '0;
    assign pf2_d  = alloc_go ? mk_pf(pf2_half, ptr_q, 1'h1, gen_q[ptr_q][1] + 1'h1) : '0;
    // a queued second pre-fetch meeting a new one is the earlier and is dropped
    assign incoming = new_pf.valid ? new_pf : pf2_q;

    always_comb begin
        bump    = '0;
        set_p   = '0;
        ret_hit = '0;
        if (alloc_go) begin
            bump[ptr_q] = 2'h3;
        end
        if (wr_hit) begin
            bump[hit_slot][hit_half] = 1'h1;
        end
        if (refetch_go) begin
            bump[hit_slot][oth] = 1'h1;
        end
        if (out_fire) begin
            set_p[pfo_q.slot][pfo_q.half] = gen_q[pfo_q.slot][pfo_q.half] == pfo_q.gen;
        end
        if (PF_RET.valid) begin
            ret_hit[PF_RET.slot][PF_RET.half] = pend_q[PF_RET.slot][PF_RET.half] &
                                                (gen_q[PF_RET.slot][PF_RET.half] == PF_RET.gen);
        end
    end

    // a bump wins over an issue leaving on the same edge, so the old one stays stale
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            valid_q <= '0;
            have_q  <= '0;
            pend_q  <= '0;
            gen_q   <= '0;
            ptr_q   <= '0;
        end else begin
            for (int i = 0; i < NUM_ENTRIES; i++) begin
                for (int h = 0; h < 2; h++) begin
                    if (bump[i][h]) begin
                        gen_q[i][h]  <= gen_q[i][h] + 1'h1;
                        pend_q[i][h] <= 1'h0;
                        have_q[i][h] <= 1'h0;
                    end else if (ret_hit[i][h]) begin
                        pend_q[i][h] <= 1'h0;
                        have_q[i][h] <= PF_RET.ok;
                    end else if (set_p[i][h]) begin
                        pend_q[i][h] <= 1'h1;
                    end
                end
            end
            if (alloc_go) begin
                valid_q[ptr_q] <= 1'h1;
                ptr_q          <= ptr_q + 1'h1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (alloc_go) begin
            base_q[ptr_q] <= pf1_half;
        end
        if (ret_hit != '0) begin
            data_q[PF_RET.slot][PF_RET.half] <= PF_RET.data;
        end
    end

    // stage and output registers of the issue pipeline
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            pf2_q <= '0;
            stg_q <= '0;
            pfo_q <= '0;
        end else begin
            pf2_q <= pf2_d;
            if (out_free) begin
                pfo_q <= stg_q.valid ? stg_q : incoming;
                stg_q <= stg_q.valid ? incoming : '0;
            end else if (incoming.valid) begin
                stg_q <= incoming;
            end
        end
    end

    always_comb begin
        rsp_d = '0;
        fwd_d = '0;
        if (data_hit) begin
            rsp_d.valid = 1'h1;
            rsp_d.id    = REQ.id;
            rsp_d.data  = pick(hit_slot, need);
        end else if (wait_done & wait_ok) begin
            rsp_d.valid = 1'h1;
            rsp_d.id    = wait_id_q;
            rsp_d.data  = pick(wait_slot_q, wait_need_q);
        end
        if (acc & (REQ.write | ~(data_hit | wait_hit))) begin
            fwd_d.valid = 1'h1;
            fwd_d.write = REQ.write;
            fwd_d.id    = REQ.id;
            fwd_d.addr  = REQ.addr;
        end else if (wait_done & ~wait_ok) begin
            fwd_d.valid = 1'h1;
            fwd_d.write = 1'h0;
            fwd_d.id    = wait_id_q;
            fwd_d.addr  = wait_addr_q;
        end
    end

    // new requests are held off while a read waits, so answers never collide
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            rsp_q    <= '0;
            fwd_q    <= '0;
            rdy_q    <= 1'h0;
            wait_v_q <= 1'h0;
        end else begin
            rsp_q    <= rsp_d;
            fwd_q    <= fwd_d;
            rdy_q    <= rdy_d;
            wait_v_q <= wait_hit | (wait_v_q & ~wait_done);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (wait_hit) begin
            wait_id_q   <= REQ.id;
            wait_addr_q <= REQ.addr;
            wait_slot_q <= hit_slot;
            wait_need_q <= need;
        end
    end

    assign REQ_READY    = rdy_q;
    assign RSP          = rsp_q;
    assign FWD          = fwd_q;
    assign PF_OUT       = pfo_q;
    assign STREAM_VALID = valid_q;
    assign ALLOC_PTR    = ptr_q;

endmodule

// ---- verification/dspb_top_sva.sv ----
// concurrent checks on the ports of the stream pre-fetch buffer
`timescale 1ns/1ps
module dspb_chk (
    input logic                             CORE_CLK,
    input logic                             NRST,
    input dspb_pkg::dspb_req_t              REQ,
    input logic                             REQ_READY,
    input dspb_pkg::dspb_rsp_t              RSP,
    input dspb_pkg::dspb_fwd_t              FWD,
    input dspb_pkg::dspb_pf_t               PF_OUT,
    input logic                             PF_READY,
    input logic [dspb_pkg::NUM_ENTRIES-1:0] STREAM_VALID,
    input logic [dspb_pkg::SLOT_W-1:0]      ALLOC_PTR
);
    import dspb_pkg::*;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    AST_RST_CLEAR: assert property (
        $rose(NRST) |-> !REQ_READY && STREAM_VALID == '0 && ALLOC_PTR == '0 && !PF_OUT.valid ##1 REQ_READY)
        else $error("reset state");
    AST_ONE_ANSWER: assert property (!(RSP.valid && FWD.valid))
        else $error("two answers");
    AST_ANSWER_NEXT: assert property (
        REQ.valid && REQ_READY |=> RSP.valid || FWD.valid || !REQ_READY)
        else $error("no answer");
    AST_NO_SPURIOUS: assert property (
        RSP.valid || FWD.valid |-> $past(REQ.valid && REQ_READY) || $past(!REQ_READY))
        else $error("stray answer");
    AST_WRITE_FWD: assert property (
        REQ.valid && REQ_READY && REQ.write |=> FWD.valid && FWD.write && FWD.addr == $past(REQ.addr))
        else $error("write lost");
    AST_READ_FWD: assert property (
        $past(REQ.valid && REQ_READY && !REQ.write) && FWD.valid |->
        !FWD.write && FWD.addr == $past(REQ.addr) && FWD.id == $past(REQ.id))
        else $error("read forward");
    AST_RSP_ID: assert property (
        $past(REQ.valid && REQ_READY) && RSP.valid |-> RSP.id == $past(REQ.id))
        else $error("response id");
    AST_PF_HOLD: assert property (PF_OUT.valid && !PF_READY |=> PF_OUT.valid)
        else $error("stalled pre-fetch lost");
    AST_PTR_STEP: assert property (
        $changed(ALLOC_PTR) |-> ALLOC_PTR == $past(ALLOC_PTR) + 3'h1 && STREAM_VALID[$past(ALLOC_PTR)])
        else $error("pointer step");
    AST_PF1_SLOT: assert property (
        $changed(ALLOC_PTR) && !$past(PF_OUT.valid) |->
        PF_OUT.valid && !PF_OUT.half && PF_OUT.slot == $past(ALLOC_PTR) && PF_OUT.addr[5:0] == 6'h00)
        else $error("first pre-fetch");
    AST_PF2_NEXT: assert property (
        $changed(ALLOC_PTR) && !$past(PF_OUT.valid) && PF_READY && !(REQ.valid && REQ_READY)
        |=> PF_OUT.valid && PF_OUT.half && PF_OUT.slot == $past(PF_OUT.slot)
        && PF_OUT.addr == $past(PF_OUT.addr) + 32'h0000_0040)
        else $error("second pre-fetch");
endmodule
bind dspb_top dspb_chk u_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .REQ(REQ), .REQ_READY(REQ_READY), .RSP(RSP),
    .FWD(FWD), .PF_OUT(PF_OUT), .PF_READY(PF_READY), .STREAM_VALID(STREAM_VALID), .ALLOC_PTR(ALLOC_PTR));

// ---- verification/dspb_mem_model.sv ----
// behavioural shared memory controller answering pre-fetch reads
`timescale 1ns/1ps
module dspb_mem_model (
    input  logic                clk,
    input  logic                rst_n,
    input  dspb_pkg::dspb_pf_t  pf,
    input  logic                stall,
    input  logic                fail,
    input  logic [7:0]          delay,
    output logic                ready,
    output dspb_pkg::dspb_ret_t ret
);
    import dspb_pkg::*;
    dspb_pf_t q[$];
    int       due[$];
    int       cyc = 0;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ready <= ~stall;
        if (!rst_n) begin
            q.delete();
            due.delete();
        end else if (pf.valid && ready) begin
            q.push_back(pf);
            due.push_back(cyc + int'(delay));
        end
        if (rst_n && q.size() > 0 && due[0] <= cyc) begin
            ret <= '{1'b1, ~fail, q[0].slot, q[0].half, q[0].gen, {16{q[0].addr}}};
            void'(q.pop_front());
            void'(due.pop_front());
        end else begin
            ret.valid <= 1'b0;
            ret.data <= ~ret.data;
        end
    end
endmodule

// ---- verification/test_dspb_top.sv ----
// self-checking bench for the stream pre-fetch buffer
`timescale 1ns/1ps
module test_dspb_top;
    import dspb_pkg::*;
    localparam logic [31:0] st1 = 32'h0000_0040;
    localparam logic [31:0] st2 = 32'h0000_0080;
    localparam logic [31:0] st3 = 32'h0000_00c0;
    logic              CORE_CLK;
    logic              NRST;
    dspb_req_t         REQ;
    logic              REQ_READY;
    dspb_attr_wr_t     ATTR_WR;
    logic [2:0]        l2f;
    dspb_rsp_t         RSP;
    dspb_fwd_t         FWD;
    dspb_pf_t          PF_OUT;
    logic              PF_READY;
    dspb_ret_t         PF_RET;
    logic [7:0]        STREAM_VALID;
    logic [SLOT_W-1:0] ALLOC_PTR;
    logic              stall;
    logic              fail;
    logic              rnd_on;
    logic [7:0]        delay;
    dspb_rsp_t         rsp_s;
    dspb_fwd_t         fwd_s;
    dspb_pf_t          pf_s;
    logic [31:0]       seed;
    logic [31:0]       x;
    logic [SLOT_W-1:0] p;
    int                ret_n;
    int                cycles;
    int                miscompares;
    int                n_tests;
    logic [7:0]        regs [7] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h20};

    dspb_top uut (.CORE_CLK(CORE_CLK), .NRST(NRST), .REQ(REQ), .REQ_READY(REQ_READY), .ATTR_WR(ATTR_WR),
        .L2_DISABLED(l2f[0]), .L2_SIZE_ZERO(l2f[1]), .L2_FROZEN(l2f[2]), .RSP(RSP), .FWD(FWD), .PF_OUT(PF_OUT),
        .PF_READY(PF_READY), .PF_RET(PF_RET), .STREAM_VALID(STREAM_VALID), .ALLOC_PTR(ALLOC_PTR));
    dspb_mem_model mem (.clk(CORE_CLK), .rst_n(NRST), .pf(PF_OUT), .stall(stall), .fail(fail), .delay(delay),
        .ready(PF_READY), .ret(PF_RET));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] addr_in(input logic [7:0] r);
        logic [31:0] v;
        v = rnd();
        return {r, v[23:12], 12'h000};
    endfunction
    function automatic logic alloc_ok(input logic [7:0] r);
        return (r >= 8'h0C && r <= 8'h0F && r != 8'h0D) || r == 8'h20;
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk512(input logic [HALF_BITS-1:0] got, input logic [31:0] a);
        n_tests++;
        if (got !== {16{a}}) begin
            miscompares++;
            $display("BAD %0t data", $time);
        end
    endtask
    task automatic req(input logic w, input logic l2, input logic [31:0] a);
        int n;
        n = 0;
        @(negedge CORE_CLK);
        REQ = '{1'b1, w, 1'b1, l2, a[9:6], a};
        while (REQ_READY !== 1'b1 && n < 400) begin
            @(negedge CORE_CLK);
            n++;
        end
        @(negedge CORE_CLK);
        REQ.valid = 1'b0;
        pf_s = PF_OUT;
        while (RSP.valid !== 1'b1 && FWD.valid !== 1'b1 && n < 400) begin
            @(negedge CORE_CLK);
            n++;
        end
        rsp_s = RSP;
        fwd_s = FWD;
        chk32({31'b0, n < 400}, 32'h1);
    endtask
    task automatic attr(input logic sup, input logic [7:0] r, input logic c, input logic pe);
        @(negedge CORE_CLK);
        ATTR_WR = '{1'b1, sup, r, c, pe};
        @(negedge CORE_CLK);
        ATTR_WR.valid = 1'b0;
    endtask
    task automatic stream(input logic [31:0] a, input logic exp, input logic wt);
        logic [SLOT_W-1:0] p0;
        int                k;
        p0 = ALLOC_PTR;
        req(1'b0, 1'b0, a);
        chk32({31'b0, fwd_s.valid}, 32'h1);
        req(1'b0, 1'b0, a + st1);
        k = ret_n;
        chk32({29'b0, ALLOC_PTR}, {29'b0, exp ? p0 + 3'h1 : p0});
        if (exp && !rnd_on) chk32(pf_s.addr, a + st2);
        while (wt && exp && ret_n < k + 2) @(negedge CORE_CLK);
    endtask

    initial begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (PF_RET.valid) ret_n <= ret_n + 1;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    always @(negedge CORE_CLK) if (rnd_on) stall <= rnd() > 32'h9000_0000;

    initial begin
        seed = 32'h0000_efb3;
        {NRST, stall, fail, rnd_on, l2f} = '0;
        REQ = '0;
        ATTR_WR = '0;
        delay = 8'h01;
        {ret_n, cycles, miscompares, n_tests} = '0;
        repeat (8) @(negedge CORE_CLK);
        NRST = 1'b1;
        @(negedge CORE_CLK);
        chk32({24'b0, STREAM_VALID, 5'b0, ALLOC_PTR}, 32'h0);
        $display("test reset done");
        attr(1'b1, 8'h0D, 1'b1, 1'b0);
        attr(1'b0, 8'h0E, 1'b1, 1'b0);
        attr(1'b1, 8'h20, 1'b1, 1'b1);
        rnd_on = 1'b1;
        foreach (regs[i]) stream(addr_in(regs[i]), alloc_ok(regs[i]), 1'b1);
        rnd_on = 1'b0;
        @(negedge CORE_CLK);
        stall = 1'b0;
        $display("test regions done");
        x = addr_in(8'h0C);
        stream(x, 1'b1, 1'b1);
        req(1'b0, 1'b0, x + st2);
        chk512(rsp_s.data[HALF_BITS-1:0], x + st2);
        p = ALLOC_PTR;
        req(1'b0, 1'b0, x + st3);
        chk512(rsp_s.data[HALF_BITS-1:0], x + st3);
        chk32({29'b0, ALLOC_PTR}, {29'b0, p + 3'h1});
        $display("test data hit done");
        for (int f = 0; f < 4; f++) begin
            l2f = (f == 0) ? 3'h0 : 3'(1 << (f - 1));
            x = addr_in(8'h20);
            stream(x, 1'b1, 1'b1);
            req(1'b0, 1'b1, x + st3);
            chk512(rsp_s.data[HALF_BITS-1:0], x + ((f == 0) ? st2 : st3));
            if (f == 0) chk512(rsp_s.data[LINE_BITS-1:HALF_BITS], x + st3);
        end
        l2f = 3'h0;
        $display("test l2 modes done");
        x = addr_in(8'h0F);
        stream(x, 1'b1, 1'b1);
        req(1'b1, 1'b0, x + st2);
        chk32({31'b0, fwd_s.valid & fwd_s.write}, 32'h1);
        req(1'b0, 1'b0, x + st2);
        chk32({30'b0, fwd_s.valid, rsp_s.valid}, 32'h2);
        $display("test write done");
        fail = 1'b1;
        x = addr_in(8'h0C);
        stream(x, 1'b1, 1'b1);
        fail = 1'b0;
        for (int f = 0; f < 4; f++) req(1'b0, 1'b0, addr_in(8'h0E));
        req(1'b0, 1'b0, x + st2);
        chk32({30'b0, fwd_s.valid, rsp_s.valid}, 32'h2);
        chk32(pf_s.valid ? pf_s.addr : 32'h0, x + st3);
        $display("test refetch done");
        delay = 8'h64;
        x = addr_in(8'h0F);
        stream(x, 1'b1, 1'b0);
        // a pre-fetch only counts as outstanding once taken, else the read is forwarded
        repeat (2) @(negedge CORE_CLK);
        req(1'b0, 1'b0, x + st2);
        chk512(rsp_s.data[HALF_BITS-1:0], x + st2);
        for (int f = 0; f < 9; f++) begin
            x = addr_in(8'h0C);
            stream(x, 1'b1, 1'b0);
        end
        repeat (2) @(negedge CORE_CLK);
        req(1'b0, 1'b0, x + st2);
        chk512(rsp_s.data[HALF_BITS-1:0], x + st2);
        $display("test stale done");
        give_verdict();
    end
endmodule
